//--- verilog/vfx_core.sv
/*
 * vfx_core: vector condition flags, condition aliases, vector trap control,
 * exception class report, active-element floating-point exceptions and
 * move-prefix restart and fault addresses, with an apb register file.
 * assumes: all inputs synchronous to clock_i; event inputs are one-cycle
 * pulses qualified by ce_i; apb master follows the usual two-phase protocol.
 */
// Added by the designer: the register offsets and the APB slave port.
// Behaviour
// RL1: first active element true sets negative; overflow always cleared.
// RL2: zero cleared if any active element true, else set.
// RL3: carry cleared if last active element true, else set.
// RL4: flags come from a predicate test or a flag-setting predicate result.
// RL5: only governing-active elements count for first, any and last.
// RL6: unpredicated flag setting uses an all-true governing predicate.
// RL7: more-after-last is C and not Z; last-or-none is not C or Z.
// RL8: compare-terminate: N equal V continues, N unequal V stops.
// RL9: three-level vector traps; host select picks hyp trap or enable field.
// RL10: trapped vector or length-register access reports class 0b011001.
// RL11: floating-point exceptions only from active elements.
// RL12: legal pair, prefix changed nothing: restart at prefix address.
// RL13: legal pair, prefix changed state: restart at prefixed instruction.
// RL14: illegal pair: either address may be the restart address.
// RL15: only prefixed fetch aborts: report its syndrome and fault address.
// RL16: both fetches abort: fault address is the prefix address.
// RL17: predicate element true when its lowest bit is one.
// RL18: one predicate bit per byte, elements of 1, 2, 4 or 8 bits.
// RL19: first active is lowest true governing element, last is highest.
`timescale 1ns/1ns
`include "vfx_defs.svh"

module vfx_core import vfx_pkg::*; #(
    parameter int PB = 32
) (
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // predicate test
    input wire logic test_valid_i,
    input wire logic test_unpred_i,
    input wire logic [PB-1:0] test_gov_i,
    input wire logic [PB-1:0] test_res_i,
    input wire logic [1:0] test_esize_i,
    // compare and terminate
    input wire logic compare_terminate_op_valid_i,
    input wire logic compare_terminate_op_n_i,
    input wire logic compare_terminate_op_v_i,
    // flag view
    output vfx_flags_s flags_o,
    output vfx_cond_s cond_o,
    // vector instruction trap check
    input wire logic vec_exec_i,
    input wire logic vec_len_reg_i,
    input wire vfx_el_t cur_el_i,
    output logic vec_trap_o,
    output vfx_el_t trap_el_o,
    // floating point
    input wire logic fp_valid_i,
    input wire logic [PB-1:0] fp_gov_i,
    input wire logic [1:0] fp_esize_i,
    input wire logic [PB-1:0] fp_raw_i,
    output logic [PB-1:0] fp_exc_o,
    // move-prefix pair fault
    input wire logic pfx_valid_i,
    input wire vfx_pfx_s pfx_i,
    input wire logic pfx_pick_instr_i,
    output logic [31:0] restart_addr_o,
    output logic [31:0] fault_addr_o,
    output logic [5:0] class_o,
    // interrupt
    output logic irq_o
);
    logic [`VFX_CTRL_W-1:0] ctrl_r;
    vfx_flags_s flags_r;
    logic [`VFX_IRQ_W-1:0] stat_r;
    logic [`VFX_IRQ_W-1:0] mask_r;
    logic [5:0] class_r;
    logic [31:0] restart_r;
    logic [31:0] fault_r;
    logic [PB-1:0] fp_exc_r;
    logic vec_trap_r;
    vfx_el_t trap_el_r;
    logic [31:0] rdata_r;
    logic slverr_r;

    logic [PB-1:0] t_gov;
    logic [PB-1:0] t_act;
    logic t_first;
    logic t_any;
    logic t_last;
    logic [PB-1:0] f_act;
    logic trap_hit;
    vfx_el_t trap_el;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic [`VFX_IRQ_W-1:0] events;

    assign t_gov = test_unpred_i ? {PB{1'b1}} : test_gov_i; // RL6

    vfx_pred_scan #(.PB(PB)) u_test_scan (
        .gov_i(t_gov),
        .res_i(test_res_i),
        .esize_i(test_esize_i),
        .active_o(t_act),
        .first_o(t_first),
        .any_o(t_any),
        .last_o(t_last)
    );

    vfx_pred_scan #(.PB(PB)) u_fp_scan (
        .gov_i(fp_gov_i),
        .res_i(fp_raw_i),
        .esize_i(fp_esize_i),
        .active_o(f_act),
        .first_o(),
        .any_o(),
        .last_o()
    );

    // apb: zero wait state, every access answered in its first access cycle
    assign pready = 1'b1;
    assign wr_en = ce_i && psel && penable && pwrite;
    assign rd_en = ce_i && psel && !penable && !pwrite;
    always_comb begin
        unique case (paddr)
            `VFX_OFS_CTRL, `VFX_OFS_FLAGS, `VFX_OFS_IRQ_STAT, `VFX_OFS_IRQ_MASK,
            `VFX_OFS_SYNDROME, `VFX_OFS_RESTART, `VFX_OFS_FAULT, `VFX_OFS_FP_EXC: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl_r <= `VFX_CTRL_RST;
        end else if (wr_en && paddr == `VFX_OFS_CTRL) begin
            ctrl_r <= pwdata[`VFX_CTRL_W-1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mask_r <= '0;
        end else if (wr_en && paddr == `VFX_OFS_IRQ_MASK) begin
            mask_r <= pwdata[`VFX_IRQ_W-1:0];
        end
    end

    // read data latched in the setup cycle so it is steady through access
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_r <= '0;
            slverr_r <= 1'b0;
        end else if (ce_i && psel && !penable) begin
            slverr_r <= !mapped;
            rdata_r <= '0;
            if (rd_en) begin
                unique case (paddr)
                    `VFX_OFS_CTRL: rdata_r <= 32'(ctrl_r);
                    `VFX_OFS_FLAGS: rdata_r <= 32'({flags_r.n, flags_r.z, flags_r.c, flags_r.v});
                    `VFX_OFS_IRQ_STAT: rdata_r <= 32'(stat_r);
                    `VFX_OFS_IRQ_MASK: rdata_r <= 32'(mask_r);
                    `VFX_OFS_SYNDROME: rdata_r <= 32'(class_r);
                    `VFX_OFS_RESTART: rdata_r <= restart_r;
                    `VFX_OFS_FAULT: rdata_r <= fault_r;
                    `VFX_OFS_FP_EXC: rdata_r <= 32'(fp_exc_r);
                    default: rdata_r <= '0;
                endcase
            end
        end
    end
    assign prdata = rdata_r;
    assign pslverr = psel && penable && slverr_r;

    // condition flags: a test rewrites all four, compare-terminate only N and V
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            flags_r <= `VFX_FLG_RST;
        end else if (ce_i && test_valid_i) begin // RL4
            flags_r.n <= t_first; // RL1
            flags_r.z <= !t_any; // RL2
            flags_r.c <= !t_last; // RL3
            flags_r.v <= 1'b0; // RL1
        end else if (ce_i && compare_terminate_op_valid_i) begin
            flags_r.n <= compare_terminate_op_n_i; // RL8
            flags_r.v <= compare_terminate_op_v_i; // RL8
        end
    end
    assign flags_o = flags_r;

    always_comb begin
        cond_o.more_after_last = flags_r.c && !flags_r.z; // RL7
        cond_o.last_or_none = !flags_r.c || flags_r.z; // RL7
        cond_o.term_continue = flags_r.n == flags_r.v; // RL8
        cond_o.term_stop = flags_r.n != flags_r.v; // RL8
        cond_o.not_last = flags_r.c;
        cond_o.not_first = !flags_r.n;
    end

    // trap check, most privileged control first; trap goes to that level
    always_comb begin
        trap_hit = 1'b0;
        trap_el = 2'h0;
        if (!ctrl_r[`VFX_CTRL_TOP_EN]) begin // RL9
            trap_hit = 1'b1;
            trap_el = 2'h3;
        end else if (cur_el_i != 2'h3 && !ctrl_r[`VFX_CTRL_HOST_SEL] && ctrl_r[`VFX_CTRL_HYP_TRAP]) begin // RL9
            trap_hit = 1'b1;
            trap_el = 2'h2;
        end else if (cur_el_i != 2'h3 && ctrl_r[`VFX_CTRL_HOST_SEL] && !ctrl_r[`VFX_CTRL_HYP_HOST_EN]) begin // RL9
            trap_hit = 1'b1;
            trap_el = 2'h2;
        end else if (cur_el_i <= 2'h1 && !ctrl_r[`VFX_CTRL_KERN_EN]) begin // RL9
            trap_hit = 1'b1;
            trap_el = 2'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            vec_trap_r <= 1'b0;
            trap_el_r <= 2'h0;
        end else if (ce_i) begin
            vec_trap_r <= (vec_exec_i || vec_len_reg_i) && trap_hit;
            if ((vec_exec_i || vec_len_reg_i) && trap_hit) begin
                trap_el_r <= trap_el;
            end
        end
    end
    assign vec_trap_o = vec_trap_r;
    assign trap_el_o = trap_el_r;

    // syndrome, restart and fault addresses; a trap and a prefix fault in
    // one cycle cannot both be architectural, the trap is reported
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            class_r <= 6'h00;
            restart_r <= 32'h0000_0000;
            fault_r <= 32'h0000_0000;
        end else if (ce_i && (vec_exec_i || vec_len_reg_i) && trap_hit) begin
            class_r <= `VFX_EC_VECTOR; // RL10
        end else if (ce_i && pfx_valid_i) begin
            if (pfx_i.legal) begin
                restart_r <= pfx_i.prefix_changed ? pfx_i.instr_addr : pfx_i.prefix_addr; // RL12 RL13
            end else begin
                restart_r <= pfx_pick_instr_i ? pfx_i.instr_addr : pfx_i.prefix_addr; // RL14
            end
            if (pfx_i.prefix_abort) begin
                fault_r <= pfx_i.prefix_addr; // RL16
            end else if (pfx_i.instr_abort) begin
                fault_r <= pfx_i.instr_addr; // RL15
                class_r <= pfx_i.instr_class; // RL15
            end
        end
    end
    assign class_o = class_r;
    assign restart_addr_o = restart_r;
    assign fault_addr_o = fault_r;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            fp_exc_r <= '0;
        end else if (ce_i && fp_valid_i) begin
            fp_exc_r <= fp_raw_i & f_act; // RL11
        end
    end
    assign fp_exc_o = fp_exc_r;

    // sticky status: a new event wins over a write-one clear
    assign events[`VFX_IRQ_TRAP] = (vec_exec_i || vec_len_reg_i) && trap_hit;
    assign events[`VFX_IRQ_FP] = fp_valid_i && |(fp_raw_i & f_act);
    assign events[`VFX_IRQ_PFX] = pfx_valid_i;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            stat_r <= '0;
        end else if (ce_i) begin
            stat_r <= (stat_r & ~((wr_en && paddr == `VFX_OFS_IRQ_STAT) ? pwdata[`VFX_IRQ_W-1:0] : '0)) | events;
        end
    end
    assign irq_o = |(stat_r & mask_r);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_first_neg: assert property (ce_i && test_valid_i |=> flags_r.n == $past(t_first)) // RL1
        else $error("negative flag does not follow first active element");

    a_over_clear: assert property (ce_i && test_valid_i |=> !flags_r.v) // RL1
        else $error("overflow not cleared by predicate test");

    a_zero_any: assert property (ce_i && test_valid_i |=> flags_r.z == !$past(t_any)) // RL2
        else $error("zero flag does not reflect any active true");

    a_carry_last: assert property (ce_i && test_valid_i |=> flags_r.c == !$past(t_last)) // RL3
        else $error("carry flag does not reflect last active element");

    a_unpred_all: assert property (ce_i && test_valid_i && test_unpred_i && test_res_i[0] |=> flags_r.n) // RL6
        else $error("unpredicated test ignored element zero");

    a_cond_alias: assert property (cond_o.more_after_last == !cond_o.last_or_none) // RL7
        else $error("more-after-last and last-or-none not complementary");

    a_term_cond: assert property (ce_i && compare_terminate_op_valid_i && !test_valid_i // RL8
        |=> cond_o.term_stop == ($past(compare_terminate_op_n_i) != $past(compare_terminate_op_v_i)))
        else $error("terminate condition wrong after compare");

    a_compare_terminate_op_keep: assert property (ce_i && compare_terminate_op_valid_i && !test_valid_i |=> $stable(flags_r.z)) // RL8
        else $error("compare-terminate changed the zero flag");

    a_trap_class: assert property (ce_i && vec_exec_i && trap_hit |=> vec_trap_o && class_o == 6'h19) // RL10
        else $error("trapped vector instruction without vector class");

    a_trap_top: assert property (ce_i && vec_exec_i && !ctrl_r[`VFX_CTRL_TOP_EN] |=> trap_el_o == 2'h3) // RL9
        else $error("top-level disable did not trap to level three");

    a_fp_active: assert property (ce_i && fp_valid_i |=> (fp_exc_o & ~$past(f_act)) == '0) // RL11
        else $error("inactive element raised floating-point exception");

    a_restart_legal: assert property (ce_i && pfx_valid_i && pfx_i.legal // RL12 RL13
        && !(vec_exec_i || vec_len_reg_i)
        |=> restart_addr_o == ($past(pfx_i.prefix_changed) ? $past(pfx_i.instr_addr)
        : $past(pfx_i.prefix_addr)))
        else $error("legal prefix pair restart address wrong");

    a_fault_both: assert property (ce_i && pfx_valid_i && pfx_i.prefix_abort && pfx_i.instr_abort // RL16
        && !(vec_exec_i || vec_len_reg_i) |=> fault_addr_o == $past(pfx_i.prefix_addr))
        else $error("double abort fault address not the prefix");

    // a mask write in the same cycle may legally hide the event
    a_irq_level: assert property (ce_i && |(events & mask_r) && !(wr_en && paddr == `VFX_OFS_IRQ_MASK) |=> irq_o)
        else $error("unmasked event did not raise interrupt");

    c_trap: cover property (ce_i && vec_len_reg_i && trap_hit);
    c_pfx_instr_abort: cover property (ce_i && pfx_valid_i && pfx_i.instr_abort && !pfx_i.prefix_abort);
    c_first_not_zero: cover property (ce_i && test_valid_i && !t_act[0] && t_first);
    c_fp_masked: cover property (ce_i && fp_valid_i && |(fp_raw_i & ~f_act));
    c_ce_frozen: cover property (!ce_i && test_valid_i);

endmodule : vfx_core

//--- verilog/vfx_defs.svh
/*
 * vfx_defs.svh: register offsets, field positions, reset values and fixed
 * codes of the vector flag and exception report block.
 * assumes: included by bare name from package and design files.
 */
`ifndef VFX_DEFS_SVH
`define VFX_DEFS_SVH

// apb byte offsets
`define VFX_OFS_CTRL 12'h000
`define VFX_OFS_FLAGS 12'h004
`define VFX_OFS_IRQ_STAT 12'h008
`define VFX_OFS_IRQ_MASK 12'h00c
`define VFX_OFS_SYNDROME 12'h010
`define VFX_OFS_RESTART 12'h014
`define VFX_OFS_FAULT 12'h018
`define VFX_OFS_FP_EXC 12'h01c

// control register fields
`define VFX_CTRL_TOP_EN 0
`define VFX_CTRL_HYP_TRAP 1
`define VFX_CTRL_HYP_HOST_EN 2
`define VFX_CTRL_KERN_EN 3
`define VFX_CTRL_HOST_SEL 4
`define VFX_CTRL_W 5
`define VFX_CTRL_RST 5'h0d

// flags register fields
`define VFX_FLG_V 0
`define VFX_FLG_C 1
`define VFX_FLG_Z 2
`define VFX_FLG_N 3
`define VFX_FLG_RST 4'h4

// interrupt status bits
`define VFX_IRQ_TRAP 0
`define VFX_IRQ_FP 1
`define VFX_IRQ_PFX 2
`define VFX_IRQ_W 3

// exception class for trapped vector instructions
`define VFX_EC_VECTOR 6'h19

`endif

//--- verilog/vfx_pkg.sv
/*
 * vfx_pkg: types shared by the vector flag and exception report block.
 * assumes: vfx_defs.svh on the include path.
 */
`include "vfx_defs.svh"

package vfx_pkg;

    typedef logic [1:0] vfx_el_t;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } vfx_flags_s;

    typedef struct packed {
        logic more_after_last;
        logic last_or_none;
        logic term_continue;
        logic term_stop;
        logic not_last;
        logic not_first;
    } vfx_cond_s;

    // one faulting move-prefix pair
    typedef struct packed {
        logic [31:0] prefix_addr;
        logic [31:0] instr_addr;
        logic legal;
        logic prefix_changed;
        logic prefix_abort;
        logic instr_abort;
        logic [5:0] instr_class;
    } vfx_pfx_s;

endpackage : vfx_pkg

//--- verilog/vfx_pred_scan.sv
/*
 * vfx_pred_scan: finds the active elements of a governing predicate and the
 * first, any and last results of a tested predicate over them.
 * assumes: one predicate bit per vector byte; esize_i is log2 of the element
 * width in predicate bits (0..3); purely combinational.
 */
`timescale 1ns/1ns

module vfx_pred_scan #(
    parameter int PB = 32
) (
    // predicates
    input wire logic [PB-1:0] gov_i,
    input wire logic [PB-1:0] res_i,
    input wire logic [1:0] esize_i,
    // results
    output logic [PB-1:0] active_o,
    output logic first_o,
    output logic any_o,
    output logic last_o
);
    logic [PB-1:0] hit;
    logic [3:0] emask;

    assign emask = 4'((4'h1 << esize_i) - 4'h1);

    // only the lowest bit of each element is looked at
    for (genvar i = 0; i < PB; i++) begin : g_lane
        logic [3:0] lidx;
        assign lidx = 4'(i % 16);
        assign active_o[i] = ((lidx & emask) == 4'h0) && gov_i[i]; // RL17 RL18 RL5
        assign hit[i] = active_o[i] & res_i[i];
    end

    assign any_o = |hit; // RL2

    // lowest active element wins first, highest wins last
    always_comb begin
        first_o = 1'b0;
        last_o = 1'b0;
        for (int i = PB - 1; i >= 0; i--) begin
            if (active_o[i]) begin
                first_o = res_i[i]; // RL19
            end
        end
        for (int i = 0; i < PB; i++) begin
            if (active_o[i]) begin
                last_o = res_i[i]; // RL19
            end
        end
    end

endmodule : vfx_pred_scan

//--- tb/testbench.sv
/*
 * testbench: self-checking bench for vfx_core covering flags, condition
 * aliases, trap control, fp masking, move-prefix addresses, irq and apb.
 * assumes: vfx_pkg and vfx_defs.svh compiled first; apb slave may add wait states.
 */
`timescale 1ns/1ns
`include "vfx_defs.svh"

module testbench import vfx_pkg::*; ();

    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic test_valid_i = 1'b0;
    logic test_unpred_i = 1'b0;
    logic [31:0] test_gov_i = 32'h0;
    logic [31:0] test_res_i = 32'h0;
    logic [1:0] test_esize_i = 2'h0;
    logic compare_terminate_op_valid_i = 1'b0;
    logic compare_terminate_op_n_i = 1'b0;
    logic compare_terminate_op_v_i = 1'b0;
    vfx_flags_s flags_o;
    vfx_cond_s cond_o;
    logic vec_exec_i = 1'b0;
    logic vec_len_reg_i = 1'b0;
    vfx_el_t cur_el_i = 2'h0;
    logic vec_trap_o;
    vfx_el_t trap_el_o;
    logic fp_valid_i = 1'b0;
    logic [31:0] fp_gov_i = 32'h0;
    logic [1:0] fp_esize_i = 2'h0;
    logic [31:0] fp_raw_i = 32'h0;
    logic [31:0] fp_exc_o;
    logic pfx_valid_i = 1'b0;
    vfx_pfx_s pfx_i = '0;
    logic pfx_pick_instr_i = 1'b0;
    logic [31:0] restart_addr_o;
    logic [31:0] fault_addr_o;
    logic [5:0] class_o;
    logic irq_o;
    int error_cnt = 0;
    int tests_run = 0;

    vfx_core #(.PB(32)) dut (.clock_i, .rst_i, .ce_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .test_valid_i, .test_unpred_i, .test_gov_i, .test_res_i, .test_esize_i,
        .compare_terminate_op_valid_i, .compare_terminate_op_n_i, .compare_terminate_op_v_i, .flags_o, .cond_o, .vec_exec_i, .vec_len_reg_i, .cur_el_i,
        .vec_trap_o, .trap_el_o, .fp_valid_i, .fp_gov_i, .fp_esize_i, .fp_raw_i, .fp_exc_o, .pfx_valid_i,
        .pfx_i, .pfx_pick_instr_i, .restart_addr_o, .fault_addr_o, .class_o, .irq_o);

    always #20 clock_i = ~clock_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    // element lowest bits of the governing predicate, one lane per element
    function automatic logic [31:0] act(input logic [31:0] g, input logic [1:0] es);
        logic [31:0] m;
        m = 32'h0;
        for (int k = 0; k < 32; k += (1 << es)) m[k] = g[k];
        return m;
    endfunction : act

    // returns {n,z,c,v}
    function automatic logic [3:0] ref_flags(input logic [31:0] g, input logic [31:0] r, input logic [1:0] es);
        logic [31:0] m;
        logic n, z, c, seen;
        m = act(g, es);
        n = 1'b0;
        z = 1'b1;
        c = 1'b1;
        seen = 1'b0;
        for (int k = 0; k < 32; k++) begin
            if (m[k]) begin
                if (!seen) n = r[k];
                seen = 1'b1;
                if (r[k]) z = 1'b0;
                c = ~r[k];
            end
        end
        return {n, z, c, 1'b0};
    endfunction : ref_flags

    function automatic logic [5:0] cnd(input logic [3:0] f);
        return {f[1] & ~f[2], ~f[1] | f[2], f[3] == f[0], f[3] != f[0], f[1], ~f[3]};
    endfunction : cnd

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge clock_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1) @(posedge clock_i);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let the access edge settle before callers look at outputs
        #1;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic er;
        apb(1'b1, a, d, r, er);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        logic er;
        apb(1'b0, a, 32'h0, r, er);
        chk(r, e);
        chk(er, 1'b0);
    endtask : rdchk

    // one vector attempt; returns just after the answer edge
    task automatic vpulse(input logic [1:0] el, input logic ln);
        @(posedge clock_i);
        vec_exec_i <= ~ln;
        vec_len_reg_i <= ln;
        cur_el_i <= el;
        @(posedge clock_i);
        vec_exec_i <= 1'b0;
        vec_len_reg_i <= 1'b0;
        #1;
    endtask : vpulse

    task automatic t_reset;
        chk(flags_o, 4'h4);
        chk(cond_o, cnd(4'h4));
        chk(irq_o, 1'b0);
        rdchk(`VFX_OFS_CTRL, 32'h0d);
        rdchk(`VFX_OFS_IRQ_MASK, 32'h0);
        rdchk(`VFX_OFS_FLAGS, 32'h4);
    endtask : t_reset

    task automatic t_flags;
        logic [31:0] g[8] = '{32'hffffffff, 32'h0, 32'h11111110, 32'h55555554, 32'h01010100, 32'h80000001,
                              32'h01010101, 32'hfffffff0};
        logic [31:0] r[8] = '{32'h00000001, 32'hffffffff, 32'h00000010, 32'h44444444, 32'h01000100,
                              32'h80000000, 32'hfefefefe, 32'h0000000f};
        logic [3:0] e;
        for (int i = 0; i < 8; i++) begin
            for (int es = 0; es < 4; es++) begin
                for (int u = 0; u < 2; u++) begin
                    @(posedge clock_i);
                    test_valid_i <= 1'b1;
                    test_unpred_i <= u[0];
                    test_gov_i <= g[i];
                    test_res_i <= r[i];
                    test_esize_i <= es[1:0];
                    @(posedge clock_i);
                    test_valid_i <= 1'b0;
                    #1;
                    e = ref_flags(u[0] ? 32'hffffffff : g[i], r[i], es[1:0]);
                    chk(flags_o, e);
                    chk(cond_o, cnd(e));
                end
            end
        end
        rdchk(`VFX_OFS_FLAGS, {28'h0, e});
        for (int k = 0; k < 4; k++) begin
            @(posedge clock_i);
            compare_terminate_op_valid_i <= 1'b1;
            compare_terminate_op_n_i <= k[1];
            compare_terminate_op_v_i <= k[0];
            @(posedge clock_i);
            compare_terminate_op_valid_i <= 1'b0;
            #1;
            chk(flags_o, {k[1], e[2:1], k[0]});
            chk(cond_o[3:2], {k[1] == k[0], k[1] != k[0]});
        end
        // a test offered while the clock enable is low must leave the flags alone
        @(posedge clock_i);
        ce_i <= 1'b0;
        test_valid_i <= 1'b1;
        @(posedge clock_i);
        ce_i <= 1'b1;
        test_valid_i <= 1'b0;
        #1;
        chk(flags_o, {1'b1, e[2:1], 1'b1});
    endtask : t_flags

    task automatic t_trap;
        // ctrl, level, length-register access, trapped, target level
        logic [10:0] tb[8] = '{{5'h0d, 2'd0, 1'b0, 1'b0, 2'd0}, {5'h0c, 2'd3, 1'b0, 1'b1, 2'd3},
                               {5'h0f, 2'd1, 1'b1, 1'b1, 2'd2}, {5'h1f, 2'd1, 1'b0, 1'b0, 2'd0},
                               {5'h1b, 2'd0, 1'b0, 1'b1, 2'd2}, {5'h09, 2'd1, 1'b0, 1'b0, 2'd0},
                               {5'h05, 2'd1, 1'b1, 1'b1, 2'd1}, {5'h05, 2'd2, 1'b0, 1'b0, 2'd0}};
        for (int i = 0; i < 8; i++) begin
            wr(`VFX_OFS_CTRL, {27'h0, tb[i][10:6]});
            vpulse(tb[i][5:4], tb[i][3]);
            chk(vec_trap_o, tb[i][2]);
            if (tb[i][2]) begin
                chk(class_o, `VFX_EC_VECTOR);
                chk(trap_el_o, tb[i][1:0]);
            end
            @(posedge clock_i);
            #1;
            chk(vec_trap_o, 1'b0);
        end
        rdchk(`VFX_OFS_CTRL, 32'h05);
        rdchk(`VFX_OFS_SYNDROME, 32'h19);
        wr(`VFX_OFS_CTRL, 32'h0d);
    endtask : t_trap

    task automatic t_fp;
        for (int es = 0; es < 4; es++) begin
            @(posedge clock_i);
            fp_valid_i <= 1'b1;
            fp_gov_i <= 32'h0f0f0f0f >> es;
            fp_esize_i <= es[1:0];
            fp_raw_i <= 32'hffffffff;
            @(posedge clock_i);
            fp_valid_i <= 1'b0;
            #1;
            chk(fp_exc_o, act(32'h0f0f0f0f >> es, es[1:0]));
        end
        rdchk(`VFX_OFS_FP_EXC, act(32'h0f0f0f0f >> 3, 2'd3));
    endtask : t_fp

    task automatic t_pfx;
        // legal, prefix changed, prefix abort, prefixed abort, pick prefixed
        logic [4:0] tp[7] = '{5'b10000, 5'b11010, 5'b10110, 5'b00000, 5'b00101, 5'b11000, 5'b01011};
        logic [31:0] pa, ia, ers, efa;
        logic [5:0] ecl;
        efa = 32'h0;
        ecl = 6'h19;
        for (int i = 0; i < 7; i++) begin
            pa = 32'h1000 + 32'h10 * i;
            ia = pa + 32'h4;
            ers = tp[i][4] ? (tp[i][3] ? ia : pa) : (tp[i][0] ? ia : pa);
            if (tp[i][2]) begin
                efa = pa;
            end else if (tp[i][1]) begin
                efa = ia;
                ecl = 6'h20 + i[5:0];
            end
            @(posedge clock_i);
            pfx_valid_i <= 1'b1;
            pfx_i <= {pa, ia, tp[i][4:1], 6'h20 + i[5:0]};
            pfx_pick_instr_i <= tp[i][0];
            @(posedge clock_i);
            pfx_valid_i <= 1'b0;
            #1;
            chk(restart_addr_o, ers);
            chk(fault_addr_o, efa);
            chk(class_o, ecl);
        end
        rdchk(`VFX_OFS_RESTART, ers);
        rdchk(`VFX_OFS_FAULT, efa);
    endtask : t_pfx

    task automatic t_irq;
        logic [31:0] r;
        logic er;
        chk(irq_o, 1'b0);
        wr(`VFX_OFS_IRQ_MASK, 32'h7);
        chk(irq_o, 1'b1);
        rdchk(`VFX_OFS_IRQ_STAT, 32'h7);
        wr(`VFX_OFS_IRQ_STAT, 32'h7);
        rdchk(`VFX_OFS_IRQ_STAT, 32'h0);
        chk(irq_o, 1'b0);
        wr(`VFX_OFS_IRQ_MASK, 32'h2);
        wr(`VFX_OFS_CTRL, 32'h0c);
        vpulse(2'd3, 1'b0);
        @(posedge clock_i);
        #1;
        chk(irq_o, 1'b0);
        rdchk(`VFX_OFS_IRQ_STAT, 32'h1);
        wr(`VFX_OFS_IRQ_MASK, 32'h1);
        chk(irq_o, 1'b1);
        wr(`VFX_OFS_IRQ_STAT, 32'h1);
        chk(irq_o, 1'b0);
        vpulse(2'd3, 1'b0);
        chk(irq_o, 1'b1);
        wr(`VFX_OFS_IRQ_STAT, 32'h1);
        chk(irq_o, 1'b0);
        wr(`VFX_OFS_CTRL, 32'h0d);
        // unmapped place answers with an error and zero data
        apb(1'b0, 12'h020, 32'h0, r, er);
        chk(r, 32'h0);
        chk(er, 1'b1);
        // read-only flags ignore a write
        apb(1'b0, `VFX_OFS_FLAGS, 32'h0, r, er);
        wr(`VFX_OFS_FLAGS, ~r);
        rdchk(`VFX_OFS_FLAGS, r);
    endtask : t_irq

    initial begin
        #(40 * 50000);
        error_cnt++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        #1;
        t_reset();
        t_flags();
        t_trap();
        t_fp();
        t_pfx();
        t_irq();
        finish_test();
    end
endmodule : testbench
